// ### hdl/data_memory.sv
// Small data memory with registered read data
`timescale 1ns/10ps
`default_nettype none
`include "rotate_right_defs.svh"
module data_memory
#(
    parameter int DEPTH = `ROT_MEM_DEPTH,
    parameter int AW    = `ROT_ADDR_W,
    parameter int DW    = `ROT_DATA_W
)
(
    input  wire logic          clk,
    input  wire logic [AW-1:0] rd_addr,
    output var  logic [DW-1:0] rd_data,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data
);
    logic [DW-1:0] mem [DEPTH];

    // Write port and registered read port
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule : data_memory
`default_nettype wire

// ### hdl/rotate_right_defs.svh
// Constants shared by the rotate right datapath
`ifndef ROTATE_RIGHT_DEFS_SVH
`define ROTATE_RIGHT_DEFS_SVH
`define ROT_DATA_W      8
`define ROT_MSB         7
`define ROT_WREG_RESET  8'h00
`define ROT_CARRY_RESET 1'b0
`define ROT_MEM_DEPTH   64
`define ROT_ADDR_W      6
`endif

// ### hdl/rotate_right_pkg.sv
// Types shared by the rotate right datapath
`default_nettype none
`include "rotate_right_defs.svh"
package rotate_right_pkg;
    typedef logic [`ROT_DATA_W-1:0] byte_t;
    typedef logic [`ROT_ADDR_W-1:0] addr_t;
    typedef enum logic [1:0]
    {
        OP_NONE,
        OP_ROTATE_RIGHT_TO_WORK_REG,
        OP_ROTATE_RIGHT_THROUGH_CARRY,
        OP_ROTATE_CARRY_INTO_WORK_REG
    } rot_op_e;
endpackage : rotate_right_pkg
`default_nettype wire

// ### hdl/rotate_right_unit.sv
// Rotate right datapath slice with working register and carry flag
// Timing: op_valid with op and addr in cycle 0 starts a read; in cycle 1 the
// memory byte is available and the result is committed at the end of it.
// A new op is accepted only when busy is low.
`timescale 1ns/10ps
`default_nettype none
`include "rotate_right_defs.svh"
module rotate_right_unit
(
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     op_valid,
    input  wire rotate_right_pkg::rot_op_e op,
    input  wire rotate_right_pkg::addr_t  addr,
    output logic                          busy,
    output logic                          done,
    output rotate_right_pkg::byte_t       working_register,
    output logic                          carry,
    input  wire logic                     mem_load,
    input  wire rotate_right_pkg::addr_t  mem_load_addr,
    input  wire rotate_right_pkg::byte_t  mem_load_data,
    output logic                          mem_written
);
    import rotate_right_pkg::*;

    typedef enum logic
    {
        ST_IDLE,
        ST_EXEC
    } state_e;

    state_e  state;
    state_e  next_state;
    rot_op_e cur_op;
    rot_op_e next_cur_op;
    addr_t   cur_addr;
    addr_t   next_cur_addr;
    byte_t   next_working_register;
    logic    next_carry;
    logic    next_done;
    logic    next_mem_written;
    byte_t   mem_rdata;
    byte_t   plain_rot;
    byte_t   carry_rot;
    logic    mem_we;
    addr_t   mem_waddr;
    byte_t   mem_wdata;

    // Rotations of the fetched byte
    assign plain_rot = {mem_rdata[0], mem_rdata[`ROT_MSB:1]};
    assign carry_rot = {carry, mem_rdata[`ROT_MSB:1]};

    // Memory write only for the memory destination form; loads otherwise
    always_comb
    begin
        mem_we    = mem_load;
        mem_waddr = mem_load_addr;
        mem_wdata = mem_load_data;
        if (state == ST_EXEC && cur_op == OP_ROTATE_RIGHT_THROUGH_CARRY)
        begin
            mem_we    = 1'b1;
            mem_waddr = cur_addr;
            mem_wdata = carry_rot;
        end
    end

    data_memory #(
        .DEPTH (`ROT_MEM_DEPTH),
        .AW    (`ROT_ADDR_W),
        .DW    (`ROT_DATA_W)
    ) u_mem (
        .clk     (clk),
        .rd_addr (addr),
        .rd_data (mem_rdata),
        .wr_en   (mem_we),
        .wr_addr (mem_waddr),
        .wr_data (mem_wdata)
    );

    assign busy = (state == ST_EXEC);

    // Next state of the sequencer and architectural state
    always_comb
    begin
        next_state            = state;
        next_cur_op           = cur_op;
        next_cur_addr         = cur_addr;
        next_working_register = working_register;
        next_carry            = carry;
        next_done             = 1'b0;
        next_mem_written      = 1'b0;
        unique case (state)
            ST_IDLE:
            begin
                if (op_valid && op != OP_NONE)
                begin
                    next_state    = ST_EXEC;
                    next_cur_op   = op;
                    next_cur_addr = addr;
                end
            end
            ST_EXEC:
            begin
                next_state = ST_IDLE;
                next_done  = 1'b1;
                unique case (cur_op)
                    OP_ROTATE_RIGHT_TO_WORK_REG:
                    begin
                        next_working_register = plain_rot;
                    end
                    OP_ROTATE_RIGHT_THROUGH_CARRY:
                    begin
                        next_carry       = mem_rdata[0];
                        next_mem_written = 1'b1;
                    end
                    OP_ROTATE_CARRY_INTO_WORK_REG:
                    begin
                        next_working_register = carry_rot;
                        next_carry            = mem_rdata[0];
                    end
                    default:
                    begin
                        next_done = 1'b0;
                    end
                endcase
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state            <= ST_IDLE;
            cur_op           <= OP_NONE;
            cur_addr         <= '0;
            working_register <= `ROT_WREG_RESET;
            carry            <= `ROT_CARRY_RESET;
            done             <= 1'b0;
            mem_written      <= 1'b0;
        end
        else
        begin
            state            <= next_state;
            cur_op           <= next_cur_op;
            cur_addr         <= next_cur_addr;
            working_register <= next_working_register;
            carry            <= next_carry;
            done             <= next_done;
            mem_written      <= next_mem_written;
        end
    end

    // Sequences of the executing step
    sequence s_exec_plain;
        state == ST_EXEC && cur_op == OP_ROTATE_RIGHT_TO_WORK_REG;
    endsequence
    sequence s_exec_mem;
        state == ST_EXEC && cur_op == OP_ROTATE_RIGHT_THROUGH_CARRY;
    endsequence
    sequence s_exec_wcarry;
        state == ST_EXEC && cur_op == OP_ROTATE_CARRY_INTO_WORK_REG;
    endsequence

    a_plain_result: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_exec_plain |=> working_register ==
            {$past(mem_rdata[0]), $past(mem_rdata[`ROT_MSB:1])})
        else $error("plain rotate result wrong");
    a_plain_no_flag: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_exec_plain |=> $stable(carry) && !mem_written)
        else $error("plain rotate touched carry or memory");
    a_plain_no_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_exec_plain |-> mem_we == mem_load && mem_waddr == mem_load_addr)
        else $error("plain rotate wrote memory");
    a_mem_writeback: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_exec_mem |-> mem_we && mem_waddr == cur_addr
            && mem_wdata[`ROT_MSB-1:0] == mem_rdata[`ROT_MSB:1])
        else $error("memory rotate write back wrong");
    a_mem_carry: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_exec_mem |-> mem_wdata[`ROT_MSB] == carry
            ##1 carry == $past(mem_rdata[0]) && $stable(working_register))
        else $error("memory rotate carry wrong");
    a_wcarry_result: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_exec_wcarry |=> working_register[`ROT_MSB-1:0] ==
            $past(mem_rdata[`ROT_MSB:1]))
        else $error("carry rotate result wrong");
    a_wcarry_flag: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_exec_wcarry |=> carry == $past(mem_rdata[0])
            && working_register[`ROT_MSB] == $past(carry))
        else $error("carry rotate flag exchange wrong");
    a_wcarry_no_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_exec_wcarry |-> mem_we == mem_load ##1 !mem_written && done)
        else $error("carry rotate wrote memory");
endmodule : rotate_right_unit
`default_nettype wire

// ### tb/test_rotate_right_unit.sv
// Self-checking testbench for the rotate right datapath
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) \
        begin \
            bad_count++; \
            $display("BAD %s expected %h seen %h", nm, exp, got); \
        end \
    end
module test_rotate_right_unit;
    import rotate_right_pkg::*;
    logic    clk = 1'h0;
    logic    rst_n = 1'h0;
    logic    op_valid = 1'h0;
    rot_op_e op = OP_NONE;
    addr_t   addr = 6'h00;
    logic    mem_load = 1'h0;
    addr_t   mem_load_addr = 6'h00;
    byte_t   mem_load_data = 8'h00;
    logic    busy, done, carry, mem_written;
    byte_t   working_register;
    byte_t   shadow [64];
    byte_t   corner [5] = '{8'h01, 8'h80, 8'hFF, 8'h00, 8'hA5};
    byte_t   exp_wr = 8'h00;
    logic    exp_c = 1'h0;
    rot_op_e ro;
    addr_t   ra;
    int      bad_count = 0;
    int      num_checks = 0;

    // 50 MHz clock
    always #10 clk = ~clk;

    rotate_right_unit u_dut (.clk(clk), .rst_n(rst_n), .op_valid(op_valid),
        .op(op), .addr(addr), .busy(busy), .done(done),
        .working_register(working_register), .carry(carry),
        .mem_load(mem_load), .mem_load_addr(mem_load_addr),
        .mem_load_data(mem_load_data), .mem_written(mem_written));

    // Right rotation result byte with top shifted into bit 7
    function automatic byte_t rot(input byte_t v, input logic top);
        return {top, v[7:1]};
    endfunction : rot

    // Prints the counts and the verdict, then stops
    task automatic final_report;
        $display("Checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report

    // Preloads one memory byte; strobe stays up, run_op drops it
    task automatic load(input addr_t a, input byte_t d);
        mem_load = 1'h1;
        mem_load_addr = a;
        mem_load_data = d;
        shadow[a] = d;
        @(negedge clk);
    endtask : load

    // Issues one op and checks its outcome at the done cycle
    task automatic run_op(input rot_op_e o, input addr_t a);
        int    n;
        byte_t m;
        logic  wm;
        mem_load = 1'h0;
        m = shadow[a];
        wm = (o == OP_ROTATE_RIGHT_THROUGH_CARRY);
        case (o)
            OP_ROTATE_RIGHT_TO_WORK_REG: exp_wr = rot(m, m[0]);
            OP_ROTATE_RIGHT_THROUGH_CARRY: shadow[a] = rot(m, exp_c);
            default: exp_wr = rot(m, exp_c);
        endcase
        if (o != OP_ROTATE_RIGHT_TO_WORK_REG)
            exp_c = m[0];
        op_valid = 1'h1;
        op = o;
        addr = a;
        @(negedge clk);
        op_valid = 1'h0;
        `CHK("busy", 1'h1, busy)
        n = 0;
        while (done !== 1'h1 && n < 4)
        begin
            @(negedge clk);
            n++;
        end
        `CHK("latency", 1, n)
        if (n == 4)
            final_report();
        `CHK("wreg", exp_wr, working_register)
        `CHK("carry", exp_c, carry)
        `CHK("memw", wm, mem_written)
    endtask : run_op

    // Main sequence
    initial
    begin
        void'($urandom(13117));
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst_n = 1'h1;
        `CHK("rst wreg", 8'h00, working_register)
        `CHK("rst carry", 1'h0, carry)
        `CHK("rst done", 1'h0, done)
        for (int i = 0; i < 64; i++)
            load(6'(i), 8'($urandom));
        $display("Reset and preload test done");
        foreach (corner[k])
        begin
            load(6'h05, corner[k]);
            run_op(OP_ROTATE_CARRY_INTO_WORK_REG, 6'h05);
            run_op(OP_ROTATE_RIGHT_TO_WORK_REG, 6'h05);
            run_op(OP_ROTATE_RIGHT_THROUGH_CARRY, 6'h05);
            run_op(OP_ROTATE_RIGHT_TO_WORK_REG, 6'h05);
            run_op(OP_ROTATE_RIGHT_TO_WORK_REG, 6'h3F);
        end
        $display("Corner test done");
        op_valid = 1'h1;
        op = OP_NONE;
        @(negedge clk);
        op_valid = 1'h0;
        repeat (3)
        begin
            `CHK("none done", 1'h0, done)
            @(negedge clk);
        end
        `CHK("none wreg", exp_wr, working_register)
        $display("Idle op test done");
        repeat (80)
        begin
            ro = rot_op_e'(2'($urandom_range(3, 1)));
            ra = 6'($urandom);
            if ($urandom_range(3) == 0)
                load(ra, 8'($urandom));
            run_op(ro, ra);
            if (ro != OP_ROTATE_RIGHT_TO_WORK_REG)
                run_op(OP_ROTATE_RIGHT_TO_WORK_REG, ra);
        end
        $display("Random test done");
        final_report();
    end
endmodule : test_rotate_right_unit
`default_nettype wire
